// ==== acst_map.svh ====
// timing counts, command codes and widths of the serial command block
`ifndef ACST_MAP_SVH
`define ACST_MAP_SVH
`define ACST_CLK_PERIOD_NS  10
`define ACST_OSC_PERIOD_NS  400
`define ACST_OSC_DIV        (`ACST_OSC_PERIOD_NS / `ACST_CLK_PERIOD_NS)
`define ACST_OSC_CNT_W      6
`define ACST_TRISTATE_OSC   4'h8
`define ACST_CAL_SINGLE     4'h7
`define ACST_CAL_FULL       4'hE
`define ACST_SAMPLE_W       24
`define ACST_BIT_CNT_W      5
`define ACST_FIFO_DEPTH     16
`define ACST_FIFO_AW        4
`define ACST_SYNC_RESET     7'h3C
`define ACST_CMD_READ       8'h01
`define ACST_CMD_READ_CONT  8'h03
`define ACST_CMD_STOP_CONT  8'h0F
`define ACST_CMD_SELF_OCAL  8'hF1
`define ACST_CMD_SELF_GCAL  8'hF2
`define ACST_CMD_SYS_OCAL   8'hF3
`define ACST_CMD_SYS_GCAL   8'hF4
`define ACST_CMD_SELF_CAL   8'hF0
`define ACST_CMD_BUF_ON     8'h20
`define ACST_CMD_BUF_OFF    8'h21
`endif

// ==== acst_pkg.sv ====
// types of the serial command block
package acst_pkg;
   typedef enum logic [2:0] {
      MODE_IDLE = 3'h1,
      MODE_CONT = 3'h2,
      MODE_CAL  = 3'h4
   } acst_mode_type;
endpackage

// ==== acst_fifo.sv ====
// sample fifo with valid and ready on both sides
`timescale 1ns/1ps
module acst_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i || flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ==== acst_top.sv ====
// serial command interface of the converter, device side
// What this block and its host must do
// RULE1 - host keeps serial clock period within limits
// RULE2 - host waits before clocking out answer data
// RULE3 - data out released 6..10 osc after end
// RULE4 - host leaves gap between commands
// RULE5 - host waits out calibration before next command
// RULE6 - power down pin stops all logic
// RULE7 - reset pin returns everything to reset
// RULE8 - data ready output is active low
// RULE9 - sync input low resynchronises conversions
// RULE10 - chip select low selects serial interface
// RULE11 - buffer on only when pin and bit
// RULE12 - calibration end drives data ready low
// RULE13 - chip select high discards partial command
`timescale 1ns/1ps
`include "acst_map.svh"
module acst_top (
   input  wire logic                      clk_i,
   input  wire logic                      reset_i,
   input  wire logic                      sclk_i,
   input  wire logic                      din_i,
   input  wire logic                      cs_n_i,
   input  wire logic                      sclk_polarity_sel_i,
   input  wire logic                      conv_sync_n_i,
   input  wire logic                      power_down_n_i,
   input  wire logic                      reset_n_i,
   input  wire logic                      input_buffer_pin_en_i,
   input  wire logic                      sample_valid_i,
   output logic                           sample_ready_o,
   input  wire logic [`ACST_SAMPLE_W-1:0] sample_i,
   output logic                           dout_o,
   output logic                           dout_oe_n_o,
   output logic                           data_ready_n_o,
   output logic                           input_buffer_active_o,
   output logic                           cal_busy_o
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and internal clear
   logic [6:0] pin_s1;
   logic [6:0] pin_s2;
   logic       sclk_d;
   logic [1:0] pol_s;
   logic       clr;
   logic       cs_high;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       lead_edge;
   logic       trail_edge;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_s1 <= `ACST_SYNC_RESET;
         pin_s2 <= `ACST_SYNC_RESET;
         sclk_d <= 1'b0;
         pol_s  <= '0;
      end else begin
         pin_s1 <= {input_buffer_pin_en_i, reset_n_i, power_down_n_i,
                    conv_sync_n_i, cs_n_i, din_i, sclk_i};
         pin_s2 <= pin_s1;
         sclk_d <= pin_s2[0];
         pol_s  <= {pol_s[0], sclk_polarity_sel_i};
      end
   end

   // reset pin and power down both hold the whole block cleared
   assign clr = reset_i | ~pin_s2[5] | ~pin_s2[4]; // RULE6 RULE7
   assign cs_high    = pin_s2[2]; // RULE10
   assign sclk_rise  = pin_s2[0] & ~sclk_d;
   assign sclk_fall  = ~pin_s2[0] & sclk_d;
   // edges found by sampling, valid for slow serial clock
   assign lead_edge  = pol_s[1] ? sclk_fall : sclk_rise; // RULE1
   assign trail_edge = pol_s[1] ? sclk_rise : sclk_fall;

   ////////////////////////////////////////////////////////////////////////
   // master oscillator tick
   logic [`ACST_OSC_CNT_W-1:0] osc_cnt;
   logic                       osc_tick;

   assign osc_tick = (osc_cnt == `ACST_OSC_CNT_W'(`ACST_OSC_DIV - 1));

   always_ff @(posedge clk_i) begin
      if (clr || osc_tick) begin
         osc_cnt <= '0;
      end else begin
         osc_cnt <= osc_cnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command byte receiver
   logic [3:0] rx_cnt;
   logic [7:0] rx_shift;
   logic       cmd_stb;
   logic [7:0] cmd_byte;

   always_ff @(posedge clk_i) begin
      if (clr || cs_high) begin
         rx_cnt   <= '0; // RULE13
         rx_shift <= '0;
         cmd_stb  <= 1'b0;
         cmd_byte <= '0;
      end else begin
         cmd_stb <= 1'b0;
         if (lead_edge) begin
            rx_shift <= {rx_shift[6:0], pin_s2[1]};
            rx_cnt   <= rx_cnt + 1'b1;
         end else if (trail_edge && rx_cnt == 4'h8) begin
            rx_cnt   <= '0;
            cmd_stb  <= 1'b1; // RULE2
            cmd_byte <= rx_shift;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode, calibration and buffer control
   acst_pkg::acst_mode_type mode;
   logic [3:0]              cal_left;
   logic                    cal_done;
   logic                    buf_bit;
   logic                    tx_load;

   function automatic logic is_single_cal(input logic [7:0] b);
      is_single_cal = (b == `ACST_CMD_SELF_OCAL) ||
                      (b == `ACST_CMD_SELF_GCAL) ||
                      (b == `ACST_CMD_SYS_OCAL)  ||
                      (b == `ACST_CMD_SYS_GCAL);
   endfunction

   always_ff @(posedge clk_i) begin
      if (clr) begin
         mode     <= acst_pkg::MODE_IDLE;
         cal_left <= '0;
      end else begin
         case (mode)
            acst_pkg::MODE_IDLE,
            acst_pkg::MODE_CONT: begin
               if (cmd_stb && is_single_cal(cmd_byte)) begin
                  mode     <= acst_pkg::MODE_CAL; // RULE5
                  cal_left <= `ACST_CAL_SINGLE;
               end else if (cmd_stb && cmd_byte == `ACST_CMD_SELF_CAL) begin
                  mode     <= acst_pkg::MODE_CAL; // RULE5
                  cal_left <= `ACST_CAL_FULL;
               end else if (cmd_stb && cmd_byte == `ACST_CMD_READ_CONT) begin
                  mode <= acst_pkg::MODE_CONT;
               end else if (cmd_stb && cmd_byte == `ACST_CMD_STOP_CONT) begin
                  mode <= acst_pkg::MODE_IDLE;
               end
            end
            acst_pkg::MODE_CAL: begin
               // one data-ready period per conversion result
               if (sample_valid_i) begin
                  cal_left <= cal_left - 1'b1;
                  if (cal_left == 4'h1) begin
                     mode <= acst_pkg::MODE_IDLE;
                  end
               end
            end
            default: begin
               mode <= acst_pkg::MODE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         cal_done <= 1'b0;
      end else if (mode == acst_pkg::MODE_CAL && sample_valid_i &&
                   cal_left == 4'h1) begin
         cal_done <= 1'b1; // RULE12
      end else if (tx_load || !pin_s2[3]) begin
         cal_done <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         buf_bit <= 1'b0;
      end else if (cmd_stb && cmd_byte == `ACST_CMD_BUF_ON) begin
         buf_bit <= 1'b1;
      end else if (cmd_stb && cmd_byte == `ACST_CMD_BUF_OFF) begin
         buf_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         input_buffer_active_o <= 1'b0;
      end else begin
         input_buffer_active_o <= pin_s2[6] & buf_bit; // RULE11
      end
   end

   assign cal_busy_o = (mode == acst_pkg::MODE_CAL);

   ////////////////////////////////////////////////////////////////////////
   // sample fifo
   logic                      fifo_in_ready;
   logic                      fifo_valid;
   logic [`ACST_SAMPLE_W-1:0] fifo_data;
   logic                      fifo_flush;

   // sync low throws away pending results and restarts
   assign fifo_flush     = ~pin_s2[3]; // RULE9
   assign sample_ready_o = cal_busy_o | (fifo_in_ready & ~fifo_flush);

   acst_fifo #(
      .WIDTH (`ACST_SAMPLE_W),
      .DEPTH (`ACST_FIFO_DEPTH),
      .AW    (`ACST_FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (clr),
      .flush_i     (fifo_flush),
      .in_valid_i  (sample_valid_i & ~cal_busy_o),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (sample_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (tx_load),
      .out_data_o  (fifo_data)
   );

   always_ff @(posedge clk_i) begin
      if (clr) begin
         data_ready_n_o <= 1'b1;
      end else begin
         data_ready_n_o <= ~(fifo_valid | cal_done); // RULE8 RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output shifter and tri-state timing
   logic [`ACST_SAMPLE_W-1:0] tx_shift;
   logic [`ACST_BIT_CNT_W-1:0] tx_left;
   logic                      read_req;
   logic                      drive;
   logic [3:0]                tri_cnt;

   // answer is ready at once, well inside the host's wait
   assign read_req = (cmd_stb && cmd_byte == `ACST_CMD_READ) ||
                     (mode == acst_pkg::MODE_CONT && tx_left == '0 &&
                      !cs_high); // RULE2
   assign tx_load  = read_req & fifo_valid;

   always_ff @(posedge clk_i) begin
      if (clr) begin
         tx_shift <= '0;
         tx_left  <= '0;
      end else if (tx_load) begin
         tx_shift <= fifo_data;
         tx_left  <= `ACST_BIT_CNT_W'(`ACST_SAMPLE_W);
      end else if (cs_high) begin
         tx_left  <= '0; // RULE13
      end else if (trail_edge && tx_left != '0) begin
         tx_shift <= {tx_shift[`ACST_SAMPLE_W-2:0], 1'b0};
         tx_left  <= tx_left - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr) begin
         dout_o <= 1'b0;
      end else begin
         dout_o <= tx_shift[`ACST_SAMPLE_W-1];
      end
   end

   // release counts osc periods from the last edge once output is done
   always_ff @(posedge clk_i) begin
      if (clr || lead_edge || trail_edge || tx_load) begin
         tri_cnt <= '0;
      end else if (osc_tick && tx_left == '0 &&
                   tri_cnt != `ACST_TRISTATE_OSC) begin
         tri_cnt <= tri_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr || cs_high) begin
         drive <= 1'b0; // RULE3
      end else if (tx_load) begin
         drive <= 1'b1;
      end else if (tri_cnt == `ACST_TRISTATE_OSC) begin
         drive <= 1'b0; // RULE3
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dout_oe_n_o <= 1'b1;
      end else begin
         dout_oe_n_o <= ~(drive & ~cs_high & ~clr); // RULE3
      end
   end
endmodule

// ==== acst_top_chk.sv ====
// port checks of the serial command block
`timescale 1ns/1ps
module acst_top_chk (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cs_n_i,
   input wire logic conv_sync_n_i,
   input wire logic power_down_n_i,
   input wire logic reset_n_i,
   input wire logic input_buffer_pin_en_i,
   input wire logic sample_valid_i,
   input wire logic sample_ready_o,
   input wire logic dout_oe_n_o,
   input wire logic data_ready_n_o,
   input wire logic input_buffer_active_o,
   input wire logic cal_busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////
   property p_rst; $past(reset_i) |-> dout_oe_n_o && data_ready_n_o;
   endproperty
   a_rst: assert property (p_rst) else $error("not idle");
   property p_pin; !reset_n_i [*5] |-> dout_oe_n_o && !cal_busy_o;
   endproperty
   a_pin: assert property (p_pin) else $error("pin reset");
   property p_pd; !power_down_n_i [*5] |-> data_ready_n_o && !cal_busy_o;
   endproperty
   a_pd: assert property (p_pd) else $error("power down");
   property p_cs; cs_n_i [*5] |-> dout_oe_n_o;
   endproperty
   a_cs: assert property (p_cs) else $error("out driven");
   property p_sync; (!conv_sync_n_i && !cal_busy_o) [*5] |-> data_ready_n_o;
   endproperty
   a_sync: assert property (p_sync) else $error("sync");
   property p_buf; !input_buffer_pin_en_i [*5] |-> !input_buffer_active_o;
   endproperty
   a_buf: assert property (p_buf) else $error("buffer on");
   property p_data_ready_n;
      sample_valid_i && sample_ready_o && !cal_busy_o |-> ##2 !data_ready_n_o;
   endproperty
   a_data_ready_n: assert property (p_data_ready_n) else $error("no ready");
   property p_cal; $fell(cal_busy_o) && reset_n_i && power_down_n_i
      && conv_sync_n_i |-> ##[0:2] !data_ready_n_o;
   endproperty
   a_cal: assert property (p_cal) else $error("cal end");
   property p_sel; $fell(dout_oe_n_o) |-> !$past(cs_n_i, 2);
   endproperty
   a_sel: assert property (p_sel) else $error("unselected");
endmodule
bind acst_top acst_top_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .cs_n_i(cs_n_i), .conv_sync_n_i(conv_sync_n_i),
   .power_down_n_i(power_down_n_i), .reset_n_i(reset_n_i),
   .input_buffer_pin_en_i(input_buffer_pin_en_i),
   .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
   .dout_oe_n_o(dout_oe_n_o), .data_ready_n_o(data_ready_n_o),
   .input_buffer_active_o(input_buffer_active_o), .cal_busy_o(cal_busy_o));

// ==== acst_host_model.sv ====
// serial master model driving the command pins
`timescale 1ns/1ps
module acst_host_model #(
   parameter int HALF = 80
) (
   input  wire logic clk_i,
   input  wire logic pol_i,
   input  wire logic dout_i,
   input  wire logic dout_oe_n_i,
   output logic      sclk_o,
   output logic      din_o,
   output logic      cs_n_o
);
   logic sclk_lvl;

   // idle level of the serial clock follows the polarity select
   assign sclk_o = sclk_lvl ^ pol_i;

   initial begin
      sclk_lvl = 1'b0;
      din_o    = 1'b1;
      cs_n_o   = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task automatic wait_osc(input int n);
      repeat (n * 40) @(negedge clk_i);
   endtask
   task automatic sel(input logic on);
      @(negedge clk_i);
      cs_n_o = !on;
      din_o  = !din_o;
      wait_osc(4);
   endtask
   task automatic drop_cs();
      cs_n_o = 1'b1;
   endtask
   task automatic put_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         din_o = b[i];
         repeat (HALF) @(negedge clk_i);
         sclk_lvl = 1'b1;
         repeat (HALF) @(negedge clk_i);
         sclk_lvl = 1'b0;
      end
      wait_osc(4);
   endtask
   task automatic send(input logic [7:0] c);
      sel(1'b1);
      put_bits(c, 8);
      sel(1'b0);
   endtask
   task automatic get_word(input int n, output logic [23:0] w);
      w = '0;
      din_o = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         repeat (HALF) @(negedge clk_i);
         sclk_lvl = 1'b1;
         // a released line reads back inverted so it cannot pass
         w[i] = dout_oe_n_i ? ~dout_i : dout_i;
         repeat (HALF) @(negedge clk_i);
         sclk_lvl = 1'b0;
      end
   endtask
endmodule

// ==== tb_acst_top.sv ====
// self-checking bench of the serial command block
`timescale 1ns/1ps
module tb_acst_top;
   logic        clk_i, reset_i, sclk, din, cs_n, sync_n, pd_n, rst_n, buf_pin;
   logic        s_valid, s_ready, dout, dout_oe_n, data_ready_n_n, buf_act, cal_busy;
   logic [23:0] s_data;
   logic        sclk_pol;
   int          num_errors, samples_checked;
   acst_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
      .din_i(din), .cs_n_i(cs_n), .sclk_polarity_sel_i(sclk_pol),
      .conv_sync_n_i(sync_n), .power_down_n_i(pd_n), .reset_n_i(rst_n),
      .input_buffer_pin_en_i(buf_pin), .sample_valid_i(s_valid),
      .sample_ready_o(s_ready), .sample_i(s_data), .dout_o(dout),
      .dout_oe_n_o(dout_oe_n), .data_ready_n_o(data_ready_n_n),
      .input_buffer_active_o(buf_act), .cal_busy_o(cal_busy));
   acst_host_model u_host (.clk_i(clk_i), .pol_i(sclk_pol), .dout_i(dout),
      .dout_oe_n_i(dout_oe_n), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic push(input logic [23:0] d);
      @(negedge clk_i);
      s_data  = d;
      s_valid = 1'b1;
      while (!s_ready) @(negedge clk_i);
      @(negedge clk_i);
      s_valid = 1'b0;
   endtask
   task automatic t_read();
      logic [23:0] w;
      push(24'hA5C3E1);
      repeat (3) @(negedge clk_i);
      check(data_ready_n_n, 24'h0);
      u_host.sel(1'b1);
      u_host.put_bits(8'h01, 8);
      u_host.wait_osc(50);
      u_host.get_word(24, w);
      check(w, 24'hA5C3E1);
      u_host.wait_osc(5);
      check({data_ready_n_n, dout_oe_n}, 24'h2);
      u_host.wait_osc(6);
      check(dout_oe_n, 24'h1);
      u_host.sel(1'b0);
      $display("read test done");
   endtask
   task automatic t_abort();
      logic [23:0] w;
      push(24'h3C5A96);
      sclk_pol = 1'b1;
      u_host.sel(1'b1);
      u_host.put_bits(8'hF0, 4);
      u_host.sel(1'b0);
      u_host.sel(1'b1);
      u_host.put_bits(8'h01, 8);
      u_host.wait_osc(50);
      u_host.get_word(12, w);
      check({cal_busy, w[23:12]}, 24'h3C5);
      @(negedge clk_i);
      u_host.drop_cs();
      repeat (6) @(negedge clk_i);
      check(dout_oe_n, 24'h1);
      sclk_pol = 1'b0;
      $display("abort test done");
   endtask
   task automatic t_cal();
      logic [7:0] c [5] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF0};
      int n;
      for (int k = 0; k < 5; k++) begin
         n = (c[k] == 8'hF0) ? 14 : 7;
         u_host.send(c[k]);
         for (int i = 1; i < n; i++) push(24'(i));
         check(cal_busy, 24'h1);
         push(24'h0);
         repeat (3) @(negedge clk_i);
         check({cal_busy, data_ready_n_n}, 24'h0);
         sync_n = 1'b0;
         repeat (6) @(negedge clk_i);
         sync_n = 1'b1;
         repeat (3) @(negedge clk_i);
         check(data_ready_n_n, 24'h1);
      end
      $display("calibration test done");
   endtask
   task automatic t_buf();
      u_host.send(8'h20);
      check(buf_act, 24'h0);
      buf_pin = 1'b1;
      repeat (5) @(negedge clk_i);
      check(buf_act, 24'h1);
      u_host.send(8'h21);
      check(buf_act, 24'h0);
      $display("buffer test done");
   endtask
   task automatic t_pins();
      for (int p = 0; p < 2; p++) begin
         push(24'h123456);
         if (p == 0) pd_n = 1'b0;
         else rst_n = 1'b0;
         repeat (6) @(negedge clk_i);
         check({cal_busy, data_ready_n_n, dout_oe_n}, 24'h3);
         pd_n  = 1'b1;
         rst_n = 1'b1;
         repeat (4) @(negedge clk_i);
         check(data_ready_n_n, 24'h1);
      end
      $display("pin test done");
   endtask
   task automatic t_fill();
      logic [23:0] w;
      for (int i = 0; i < 16; i++) push(24'h100000 + 24'(i));
      @(negedge clk_i);
      check(s_ready, 24'h0);
      u_host.sel(1'b1);
      u_host.put_bits(8'h03, 8);
      u_host.wait_osc(50);
      for (int i = 0; i < 16; i++) begin
         u_host.get_word(24, w);
         check(w, 24'h100000 + 24'(i));
      end
      u_host.put_bits(8'h0F, 8);
      u_host.sel(1'b0);
      check(data_ready_n_n, 24'h1);
      $display("fifo test done");
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      results();
   end
   initial begin
      num_errors = 0;
      samples_checked = 0;
      {reset_i, sync_n, pd_n, rst_n} = 4'hF;
      {buf_pin, sclk_pol, s_valid, s_data} = '0;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check({dout_oe_n, data_ready_n_n, cal_busy, buf_act, s_ready}, 24'h19);
      t_read();
      t_abort();
      t_cal();
      t_buf();
      t_pins();
      t_fill();
      results();
   end
endmodule
